// file: hw/hsp_pkg.sv
// Constants and carrier types for the high-side protection and diagnosis block.
package hsp_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned NUM_OUT         = 5;
  localparam int unsigned HEATER_IDX      = 0;
  // Delays in microseconds, typical figures.
  localparam int unsigned HEATER_SD_US    = 25;
  localparam int unsigned LAMP_SD_US      = 25;
  localparam int unsigned LAMP_SDON_US    = 200;
  localparam int unsigned HEATER_SD_CYC   = HEATER_SD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LAMP_SD_CYC     = LAMP_SD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LAMP_SDON_CYC   = LAMP_SDON_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 13;

  // Per-output comparator readings from the analog stage.
  typedef struct packed {
    logic overcurrent_comparator;
    logic low_output_voltage_comparator;
    logic open_load_voltage_comparator;
  } hsp_comp_s;

  // Per-output diagnosis flags.
  typedef struct packed {
    logic short_flag;
    logic open_load_flag;
  } hsp_diag_s;

  typedef enum logic [1:0] {HSP_OFF, HSP_SWITCH_ON, HSP_ON, HSP_TRIPPED} hsp_state_e;
endpackage

// file: hw/hsp_channel.sv
// One high-side output: delay filter, shutdown latch and open-load latch.
`timescale 1ns/1ps
module hsp_channel #(
  parameter bit          IS_LAMP   = 1'b1,
  parameter int unsigned SD_CYC    = hsp_pkg::LAMP_SD_CYC,
  parameter int unsigned SDON_CYC  = hsp_pkg::LAMP_SDON_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Control
  input  wire logic                switch_request,
  input  wire logic                open_load_pullup_enable,
  input  wire logic                status_reset,
  // Analog side, already synchronised
  input  wire hsp_pkg::hsp_comp_s  comp,
  // Results
  output logic                     gate_on,
  output logic                     pullup_on,
  output hsp_pkg::hsp_diag_s       diag
);
  import hsp_pkg::*;

  hsp_state_e        state;
  hsp_state_e        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  hsp_diag_s         next_diag;
  logic              next_gate_on;
  logic              next_pullup_on;
  logic              cond;

  always_comb
  begin
    next_state = state;
    next_cnt   = '0;
    next_diag  = diag;
    cond       = 1'b0;
    // Status reset clears first so that a coincident event still sets the flag.
    if (status_reset)
    begin
      next_diag = '0;
    end
    unique case (state)
      HSP_OFF:
      begin
        if (switch_request)
        begin
          next_state = (IS_LAMP != 1'b0) ? HSP_SWITCH_ON : HSP_ON;
        end
        if (comp.open_load_voltage_comparator)
        begin
          next_diag.open_load_flag = 1'b1;
        end
      end
      HSP_SWITCH_ON:
      begin
        cond = comp.overcurrent_comparator && comp.low_output_voltage_comparator;
        if (!switch_request)
        begin
          next_state = HSP_OFF;
        end
        else if (cnt >= CNT_W'(SDON_CYC))
        begin
          next_state = cond ? HSP_TRIPPED : HSP_ON;
          next_diag.short_flag = cond | next_diag.short_flag;
        end
        else
        begin
          next_cnt = cnt + 1'b1;
        end
      end
      HSP_ON:
      begin
        if (!switch_request)
        begin
          next_state = HSP_OFF;
        end
        else if (comp.overcurrent_comparator)
        begin
          if (cnt >= CNT_W'(SD_CYC))
          begin
            next_state = HSP_TRIPPED;
            next_diag.short_flag = 1'b1;
          end
          else
          begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      HSP_TRIPPED:
      begin
        next_diag.short_flag = ~status_reset;
        if (status_reset)
        begin
          next_state = HSP_OFF;
        end
      end
    endcase
    next_gate_on   = (next_state == HSP_SWITCH_ON) || (next_state == HSP_ON);
    // pull-up follows enable in off state
    next_pullup_on = open_load_pullup_enable && !next_gate_on;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state     <= HSP_OFF;
      cnt       <= '0;
      diag      <= '0;
      gate_on   <= 1'b0;
      pullup_on <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      diag      <= next_diag;
      gate_on   <= next_gate_on;
      pullup_on <= next_pullup_on;
    end
  end
endmodule

// file: hw/hsp_top.sv
// Protection and diagnosis for the heater output and four lamp outputs.
`timescale 1ns/1ps
module hsp_top (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                resetn,
  // Control bits, index 0 is the heater
  input  wire logic [hsp_pkg::NUM_OUT-1:0]         switch_request,
  input  wire logic [hsp_pkg::NUM_OUT-1:0]         open_load_pullup_enable,
  input  wire logic                                status_reset,
  // Comparators from the analog stages
  input  wire hsp_pkg::hsp_comp_s [hsp_pkg::NUM_OUT-1:0] comp,
  // Drives to the analog stages
  output logic [hsp_pkg::NUM_OUT-1:0]              gate_on,
  output logic [hsp_pkg::NUM_OUT-1:0]              pullup_on,
  // Status bits
  output hsp_pkg::hsp_diag_s [hsp_pkg::NUM_OUT-1:0] diag
);
  import hsp_pkg::*;

  hsp_comp_s [NUM_OUT-1:0] comp_meta;
  hsp_comp_s [NUM_OUT-1:0] comp_sync;

  // Comparators are asynchronous to clk and pass two flip-flops.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      comp_meta <= '0;
      comp_sync <= '0;
    end
    else
    begin
      comp_meta <= comp;
      comp_sync <= comp_meta;
    end
  end

  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_ch
    hsp_channel #(
      .IS_LAMP  ((i == HEATER_IDX) ? 1'b0 : 1'b1),
      .SD_CYC   ((i == HEATER_IDX) ? HEATER_SD_CYC : LAMP_SD_CYC),
      .SDON_CYC (LAMP_SDON_CYC)
    ) u_ch (
      .clk                     (clk),
      .resetn                  (resetn),
      .switch_request          (switch_request[i]),
      .open_load_pullup_enable (open_load_pullup_enable[i]),
      .status_reset            (status_reset),
      .comp                    (comp_sync[i]),
      .gate_on                 (gate_on[i]),
      .pullup_on               (pullup_on[i]),
      .diag                    (diag[i])
    );
  end
endmodule

// file: bench/hsp_load.sv
// Analog stage model driving the comparators.
`timescale 1ns/1ps
module hsp_load (
  // Drives and faults
  input wire logic [4:0] gate_on,
  input wire logic [4:0] pullup_on,
  input wire logic [4:0] sg,
  input wire logic [4:0] ovl,
  input wire logic [4:0] opw,
  // Comparators
  output hsp_pkg::hsp_comp_s [4:0] comp
);
  import hsp_pkg::*;
  always_comb
    for (int i = 0; i < 5; i++)
    begin
      comp[i].overcurrent_comparator = gate_on[i] & (sg[i] | ovl[i]);
      comp[i].low_output_voltage_comparator = gate_on[i] & sg[i];
      comp[i].open_load_voltage_comparator = ~gate_on[i] & pullup_on[i] & opw[i];
    end
endmodule

// file: bench/hsp_top_sva.sv
// Port assertions for the protection block.
`timescale 1ns/1ps
module hsp_top_sva (
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] open_load_pullup_enable,
  input wire logic status_reset,
  input wire hsp_pkg::hsp_comp_s [4:0] comp,
  // Outputs
  input wire logic [4:0] gate_on,
  input wire logic [4:0] pullup_on,
  input wire hsp_pkg::hsp_diag_s [4:0] diag
);
  import hsp_pkg::*;
  logic [4:0] sf, of;
  logic [15:0] c0, n1, c2;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_comb
    for (int i = 0; i < 5; i++)
    begin
      sf[i] = diag[i].short_flag;
      of[i] = diag[i].open_load_flag;
    end
  // Over-current and on-time counts seen at the pins.
  always_ff @(posedge clk)
  begin
    c0 <= (gate_on[0] & comp[0].overcurrent_comparator) ? c0 + 16'h1 : 16'h0;
    n1 <= gate_on[1] ? n1 + 16'h1 : 16'h0;
    c2 <= (gate_on[2] & comp[2].overcurrent_comparator) ? c2 + 16'h1 : 16'h0;
  end
  sequence s_open3;
    (!gate_on[3] && !sf[3] && comp[3].open_load_voltage_comparator)[*6];
  endsequence
  a_pullup_enable: assert property ((pullup_on & ~$past(open_load_pullup_enable)) == 5'h0)
    else $error("pullup without enable");
  a_short_hold: assert property (!status_reset |=> (sf & $past(sf)) == $past(sf))
    else $error("short flag lost");
  a_open_hold: assert property (!status_reset |=> (of & $past(of)) == $past(of))
    else $error("open flag lost");
  a_open_set: assert property (s_open3 |-> of[3])
    else $error("open load missed");
  a_heater_late: assert property (c0 <= 16'h280)
    else $error("heater trip late");
  a_heater_early: assert property ($rose(sf[0]) |-> $past(c0) >= 16'h26c)
    else $error("heater trip early");
  a_lamp_window: assert property ($rose(sf[1]) |-> $past(n1) >= 16'h137e)
    else $error("switch-on trip early");
  a_lamp_run: assert property ($rose(sf[2]) |-> $past(c2) >= 16'h26c)
    else $error("on-state trip early");
endmodule
bind hsp_top hsp_top_sva hsp_top_sva_i (.clk, .resetn, .open_load_pullup_enable,
  .status_reset, .comp, .gate_on, .pullup_on, .diag);

// file: bench/hsp_top_tb.sv
// Bench for the protection and diagnosis block.
`timescale 1ns/1ps
module hsp_top_tb;
  import hsp_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic status_reset = 1'b0;
  logic [4:0] req = 5'h0, en = 5'h0, sg = 5'h0, ovl = 5'h0, opw = 5'h0;
  logic [4:0] gate_on, pullup_on;
  hsp_comp_s [4:0] comp;
  hsp_diag_s [4:0] diag;
  int fails = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk;
  hsp_top hsp_top_i (.clk(clk), .resetn(resetn), .switch_request(req),
    .open_load_pullup_enable(en), .status_reset(status_reset), .comp(comp),
    .gate_on(gate_on), .pullup_on(pullup_on), .diag(diag));
  hsp_load hsp_load_i (.gate_on(gate_on), .pullup_on(pullup_on), .sg(sg), .ovl(ovl),
    .opw(opw), .comp(comp));
  task automatic run(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic clr;
    status_reset = 1'b1;
    run(1);
    status_reset = 1'b0;
    run(3);
  endtask
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    run(10);
    resetn = 1'b1;
    en = 5'h0f;
    sg = 5'h01;
    req = 5'h01;
    run(600);
    chk({gate_on, pullup_on}, 10'h02e);
    run(100);
    chk(diag, 10'h002);
    sg = 5'h0;
    run(20);
    chk({5'h0, gate_on}, 10'h000);
    clr();
    chk({5'h0, gate_on}, 10'h001);
    $display("heater test done");
    sg = 5'h02;
    req = 5'h03;
    run(4900);
    chk({5'h0, gate_on}, 10'h003);
    run(200);
    chk(diag, 10'h008);
    sg = 5'h0;
    // Output three overloads with its voltage high, so switch-on must not trip it.
    ovl = 5'h08;
    req = 5'h0f;
    run(5100);
    chk({5'h0, gate_on}, 10'h00d);
    ovl = 5'h0c;
    run(600);
    chk({5'h0, gate_on}, 10'h005);
    run(100);
    chk({5'h0, gate_on}, 10'h001);
    chk(diag, 10'h0a8);
    ovl = 5'h0;
    clr();
    chk(diag, 10'h000);
    $display("lamp test done");
    req = 5'h0;
    opw = 5'h18;
    run(12);
    chk({5'h0, pullup_on}, 10'h00f);
    chk(diag, 10'h040);
    opw = 5'h0;
    run(10);
    chk(diag, 10'h040);
    clr();
    chk(diag, 10'h000);
    opw = 5'h18;
    run(12);
    chk(diag, 10'h040);
    resetn = 1'b0;
    run(3);
    resetn = 1'b1;
    opw = 5'h0;
    run(3);
    chk(diag, 10'h000);
    $display("open load test done");
    stop_test();
  end
endmodule
